//--- logic/ssp_port.sv
// synchronous serial shift port: word receive, word send, select byte read
`timescale 1ns/100ps
// Behaviour
// R1 - word receive samples input and gives one positive clock pulse per bit
// R2 - word receive uses 2 to 32 bits per word, same for all words
// R3 - receive modes 0,2 assemble MSB first; modes 1,3 LSB first
// R4 - modes 0,1 sample before first pulse; 2,3 before the second pulse
// R5 - receive exactly the count of words into consecutive entries then end
// R6 - both receive transfers run at 600 kbit/s; select read command bytes go out at the send rate
// R7 - word send drives data and pulses clock once per bit, 2 to 32 bits
// R8 - send mode 0 is LSB first, mode 1 MSB first
// R9 - word send runs at 800 kbit/s
// R10 - send exactly the count of words from consecutive entries then end
// R11 - select byte read drives chip select low unless no select is configured
// R12 - select byte read clocks in count bytes, one byte per entry, LSB default
// R13 - up to three command bytes go out first; unused slots are skipped
// R14 - shared line is driven for command bytes, then released for reading
// R15 - byte read order and edge follow the persistent frame order setting
// R16 - frame order 0 MSB, 1 LSB default, 2 MSB and 3 LSB late sample
// R17 - idle holds select high, clock low; select released after last byte
module ssp_port
    import ssp_pkg::*;
(
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    input  wire logic              i_start,
    input  wire logic [1:0]        i_op,
    input  wire logic [1:0]        i_mode,
    input  wire logic [5:0]        i_bits_per_word,
    input  wire logic [AW:0]       i_count,
    input  wire logic              i_order_we,
    input  wire logic [1:0]        i_frame_order_setting,
    input  wire logic              i_select_used,
    input  wire logic              i_shared_line,
    input  wire logic [2:0]        i_slot_used,
    input  wire logic [23:0]       i_command_byte_slots,
    input  wire logic              i_wr_en,
    input  wire logic [AW-1:0]     i_wr_addr,
    input  wire logic [31:0]       i_wr_data,
    input  wire logic [AW-1:0]     i_rd_addr,
    input  wire logic              i_sdi,
    output logic                   o_sclk,
    output logic                   o_sdo,
    output logic                   o_sdo_oe_n,
    output logic                   o_cs_n,
    output logic                   o_busy,
    output logic                   o_done,
    output logic [31:0]            o_rd_data,
    output logic [1:0]             o_frame_order_setting
);

    // ****************************************
    // storage and input synchroniser
    // ****************************************
    logic [31:0]     word_buffer [BUF_DEPTH];
    logic            sdi_m_q;
    logic            sdi_s_q;
    ssp_state_t      state_q;
    ssp_op_t         op_q;
    logic [1:0]      mode_q;
    logic [5:0]      nbits_q;
    logic [5:0]      bit_q;
    logic [AW:0]     words_q;
    logic [AW-1:0]   idx_q;
    logic [1:0]      cmd_q;
    logic            cmd_phase_q;
    logic [7:0]      tick_q;
    logic [31:0]     sh_q;
    logic [31:0]     acc_q;
    logic            shared_q;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sdi_m_q <= 1'b0;
            sdi_s_q <= 1'b0;
        end else begin
            sdi_m_q <= i_sdi;
            sdi_s_q <= sdi_m_q;
        end
    end

    // ****************************************
    // decode
    // ****************************************
    wire        is_recv   = (op_q == SSP_OP_RECV);
    wire        is_send   = (op_q == SSP_OP_SEND);
    wire        sending   = is_send || cmd_phase_q;
    // select read mode from frame order, word receive mode from the request
    wire [1:0]  rx_mode   = is_recv ? mode_q : o_frame_order_setting; // R15
    wire        rx_msb    = !rx_mode[0]; // R3 R16
    wire        rx_late   = rx_mode[1]; // R4 R16
    wire        tx_msb    = is_send ? mode_q[0] : !o_frame_order_setting[0]; // R8
    wire [7:0]  half      = sending ? TX_HALF : RX_HALF; // R6 R9
    wire        tick_end  = (tick_q == half - 8'h01);
    wire        last_bit  = (bit_q == nbits_q - 6'h01);
    wire [5:0]  tx_pos    = tx_msb ? nbits_q - 6'h01 - bit_q : bit_q;
    wire        tx_bit    = sh_q[tx_pos[4:0]];
    wire [5:0]  rx_pos    = rx_msb ? nbits_q - 6'h01 - bit_q : bit_q;
    wire        slot_more = (cmd_q < CMD_SLOTS);
    wire [7:0]  slot_byte = i_command_byte_slots[{cmd_q[0] ? 2'h1 : 2'h0,
                                                   3'h0} +: 8];
    wire [7:0]  cmd_byte  = (cmd_q == 2'h2) ? i_command_byte_slots[23:16] : slot_byte;
    wire        clamp_lo  = (i_bits_per_word < BITS_MIN);
    wire        clamp_hi  = (i_bits_per_word > BITS_MAX);
    wire [5:0]  req_bits  = clamp_lo ? BITS_MIN : (clamp_hi ? BITS_MAX : i_bits_per_word); // R2 R7
    wire        go        = i_start && (state_q == SSP_IDLE) && (i_count != '0);
    wire [31:0] acc_set   = acc_q | (32'h1 << rx_pos[4:0]);
    wire [31:0] acc_clr   = acc_q & ~(32'h1 << rx_pos[4:0]);

    // ****************************************
    // sequencer
    // ****************************************
    // late sampling spends one dummy pulse at the start of every word, so the bit stream lags one bit per word
    logic       pre_q;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q     <= SSP_IDLE;
            op_q        <= SSP_OP_RECV;
            mode_q      <= 2'h0;
            nbits_q     <= BYTE_BITS;
            bit_q       <= 6'h00;
            words_q     <= '0;
            idx_q       <= '0;
            cmd_q       <= 2'h0;
            cmd_phase_q <= 1'b0;
            tick_q      <= 8'h00;
            sh_q        <= 32'h0;
            acc_q       <= 32'h0;
            shared_q    <= 1'b0;
            pre_q       <= 1'b0;
            o_sclk      <= 1'b0;
            o_sdo       <= 1'b0;
            o_sdo_oe_n  <= 1'b1;
            o_cs_n      <= 1'b1;
            o_busy      <= 1'b0;
            o_done      <= 1'b0;
            o_frame_order_setting <= ORDER_RESET; // R16
        end else begin
            o_done <= 1'b0;
            if (i_order_we && state_q == SSP_IDLE) begin
                o_frame_order_setting <= i_frame_order_setting; // R15
            end
            case (state_q)
                SSP_IDLE: begin
                    o_sclk     <= 1'b0; // R17
                    o_cs_n     <= 1'b1; // R17
                    o_sdo_oe_n <= 1'b1;
                    if (go) begin
                        op_q        <= ssp_op_t'(i_op);
                        mode_q      <= i_mode;
                        nbits_q     <= (i_op == SSP_OP_READ) ? BYTE_BITS : req_bits;
                        words_q     <= i_count;
                        idx_q       <= '0;
                        cmd_q       <= 2'h0;
                        cmd_phase_q <= (i_op == SSP_OP_READ);
                        shared_q    <= i_shared_line;
                        o_busy      <= 1'b1;
                        o_cs_n      <= !((i_op == SSP_OP_READ) && i_select_used); // R11
                        state_q     <= SSP_LOAD;
                    end
                end
                SSP_LOAD: begin
                    bit_q  <= 6'h00;
                    tick_q <= 8'h00;
                    acc_q  <= 32'h0;
                    pre_q  <= rx_late;
                    if (cmd_phase_q && !slot_more) begin
                        cmd_phase_q <= 1'b0; // R14
                        o_sdo_oe_n  <= 1'b1; // R14
                    end else if (cmd_phase_q && !i_slot_used[cmd_q]) begin
                        cmd_q <= cmd_q + 2'h1; // R13
                    end else begin
                        sh_q    <= cmd_phase_q ? {24'h0, cmd_byte} : word_buffer[idx_q]; // R10 R13
                        if (sending) begin
                            o_sdo_oe_n <= 1'b0; // R14
                        end else if (shared_q) begin
                            o_sdo_oe_n <= 1'b1; // R14
                        end
                        state_q <= SSP_LOW;
                    end
                end
                SSP_LOW: begin
                    o_sclk <= 1'b0;
                    if (sending) begin
                        o_sdo <= tx_bit; // R7 R8
                    end
                    tick_q <= tick_end ? 8'h00 : tick_q + 8'h01;
                    if (tick_end) begin
                        // sample ahead of the rising edge
                        if (!sending && !pre_q) begin
                            acc_q <= sdi_s_q ? acc_set : acc_clr; // R1 R3 R12
                        end
                        o_sclk  <= 1'b1; // R1 R7
                        state_q <= SSP_HIGH;
                    end
                end
                SSP_HIGH: begin
                    tick_q <= tick_end ? 8'h00 : tick_q + 8'h01;
                    if (tick_end) begin
                        o_sclk <= 1'b0;
                        if (pre_q && !sending) begin
                            pre_q   <= 1'b0; // R4
                            state_q <= SSP_LOW;
                        end else if (last_bit) begin
                            state_q <= SSP_NEXT;
                        end else begin
                            bit_q   <= bit_q + 6'h01;
                            state_q <= SSP_LOW;
                        end
                    end
                end
                SSP_NEXT: begin
                    if (cmd_phase_q) begin
                        cmd_q   <= cmd_q + 2'h1;
                        state_q <= SSP_LOAD;
                    end else begin
                        // results are written by the buffer port below
                        idx_q   <= idx_q + AW'(1);
                        words_q <= words_q - (AW+1)'(1);
                        state_q <= (words_q == (AW+1)'(1)) ? SSP_DONE : SSP_LOAD; // R5 R10
                    end
                end
                default: begin
                    o_cs_n     <= 1'b1; // R17
                    o_sdo_oe_n <= 1'b1;
                    o_busy     <= 1'b0;
                    o_done     <= 1'b1;
                    state_q    <= SSP_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // buffer port: user writes when idle, results stored on word end
    // ****************************************
    wire        store   = (state_q == SSP_NEXT) && !cmd_phase_q && !is_send; // R5 R12
    always_ff @(posedge i_clock) begin
        if (store) begin
            word_buffer[idx_q] <= acc_q;
        end else if (i_wr_en && state_q == SSP_IDLE) begin
            word_buffer[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= 32'h0;
        end else begin
            o_rd_data <= word_buffer[i_rd_addr];
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_idle_lines: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        state_q == SSP_IDLE && $past(state_q) == SSP_IDLE |-> o_cs_n && !o_sclk) // R17
        else $error("idle lines not parked");
    a_send_drives: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        state_q == SSP_LOW && is_send |-> !o_sdo_oe_n) // R14
        else $error("send without drive");
    a_read_release: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        state_q == SSP_LOW && op_q == SSP_OP_READ && !cmd_phase_q && shared_q
        |-> o_sdo_oe_n) // R14
        else $error("shared line driven during read");
    a_done_frees: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_done |-> o_cs_n && !o_busy) // R17
        else $error("select held after done");
    a_pulse_width: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $rose(o_sclk) |-> o_sclk [*2]) // R6 R9
        else $error("clock pulse too short");
    a_recv_quiet: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        state_q == SSP_LOW && !sending |-> o_sdo_oe_n) // R14
        else $error("serial line driven while receiving");
    a_done_ends: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        state_q == SSP_DONE |=> o_done && !o_busy && state_q == SSP_IDLE) // R5 R10
        else $error("transfer did not end cleanly");

    // select read start: select goes low with the first load
    sequence s_read_go;
        go && i_op == SSP_OP_READ && i_select_used;
    endsequence
    sequence s_selected;
        state_q == SSP_LOAD && o_busy && !o_cs_n;
    endsequence
    a_select_low: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        s_read_go |=> s_selected) // R11
        else $error("select not asserted at read start");

    // ****************************************
    // pulse timing helper
    // ****************************************
    // counts high cycles; catches a rate drift that a short repetition cannot
    logic [7:0]      hi_cnt_q;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hi_cnt_q <= 8'h00;
        end else begin
            hi_cnt_q <= o_sclk ? hi_cnt_q + 8'h01 : 8'h00;
        end
    end
    a_high_time: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $fell(o_sclk) |-> $past(hi_cnt_q) == $past(half) - 8'h01) // R6 R9
        else $error("clock high time off the bit rate");
endmodule

//--- pkg/ssp_pkg.sv
// shared constants and types for the synchronous serial shift port
package ssp_pkg;
    localparam int          CLK_HZ          = 25000000;
    localparam int          RX_BPS          = 600000;
    localparam int          TX_BPS          = 800000;
    // half bit periods, rounded down so the rate never falls below the figure
    localparam logic [7:0]  RX_HALF         = 8'(CLK_HZ / RX_BPS / 2);
    localparam logic [7:0]  TX_HALF         = 8'(CLK_HZ / TX_BPS / 2);
    localparam int          BUF_DEPTH       = 16;
    localparam int          AW              = 4;
    localparam logic [5:0]  BITS_MIN        = 6'h02;
    localparam logic [5:0]  BITS_MAX        = 6'h20;
    localparam logic [5:0]  BYTE_BITS       = 6'h08;
    localparam logic [1:0]  ORDER_RESET     = 2'h1;
    localparam logic [1:0]  CMD_SLOTS       = 2'h3;

    typedef enum logic [1:0] {
        SSP_OP_RECV = 2'b00,
        SSP_OP_SEND = 2'b01,
        SSP_OP_READ = 2'b10
    } ssp_op_t;

    typedef enum logic [2:0] {
        SSP_IDLE  = 3'b000,
        SSP_LOAD  = 3'b001,
        SSP_LOW   = 3'b010,
        SSP_HIGH  = 3'b011,
        SSP_NEXT  = 3'b100,
        SSP_DONE  = 3'b101
    } ssp_state_t;
endpackage

//--- dv/ssp_peer.sv
// behavioural model of the external serial peripheral
`timescale 1ns/100ps
module ssp_peer (
    input  wire logic        i_clock,
    input  wire logic        i_clear,
    input  wire logic        i_sel_used,
    input  wire logic        i_sclk,
    input  wire logic        i_cs_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_sdo,
    input  wire logic [63:0] i_pat,
    output logic             o_sdi,
    output logic [63:0]      o_cap,
    output int               o_ncap
);
    // ***************
    // shift behaviour
    // ***************
    int   idx = 0;
    logic tog = 1'b0;
    logic sclk_q = 1'b0;
    wire  sel = !i_sel_used || !i_cs_n;
    // unselected or line not yet released: noise, so a stale bit never passes
    assign o_sdi = (sel && i_oe_n) ? i_pat[idx] : tog;
    always @(posedge i_clock) begin
        tog <= !tog;
        sclk_q <= i_sclk;
        if (i_clear) begin
            idx <= 0;
            o_cap <= 64'h0;
            o_ncap <= 0;
        end else if (sel && i_sclk && !sclk_q && !i_oe_n) begin
            o_cap <= {o_cap[62:0], i_sdo};
            o_ncap <= o_ncap + 1;
        end else if (sel && !i_sclk && sclk_q && i_oe_n) begin
            idx <= idx + 1;
        end
    end
endmodule

//--- dv/ssp_port_tb.sv
// self-checking bench for the synchronous serial shift port
`timescale 1ns/100ps
module ssp_port_tb;
    import ssp_pkg::*;
    logic        i_clock, i_rst_n, i_start, i_order_we, i_select_used, i_shared_line;
    logic        i_wr_en, clr, o_sclk, o_sdo, o_sdo_oe_n, o_cs_n, o_busy, o_done;
    logic        peer_sdi, sclk_p, sawcs;
    logic [1:0]  i_op, i_mode, i_frame_order_setting, o_frame_order_setting;
    logic [5:0]  i_bits_per_word;
    logic [AW:0] i_count;
    logic [2:0]  i_slot_used;
    logic [23:0] i_command_byte_slots;
    logic [AW-1:0] i_wr_addr, i_rd_addr;
    logic [31:0] i_wr_data, o_rd_data;
    logic [63:0] pat, cap;
    logic [31:0] src [3] = '{32'hB5E17C29, 32'h4A9D03F6, 32'hE27BC815};
    int          ncap, bad_count, comparisons, rises, per, cyc, last;
    wire         i_sdi = (i_shared_line && !o_sdo_oe_n) ? o_sdo : peer_sdi;
    ssp_port dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_start(i_start), .i_op(i_op),
        .i_mode(i_mode), .i_bits_per_word(i_bits_per_word), .i_count(i_count),
        .i_order_we(i_order_we), .i_frame_order_setting(i_frame_order_setting),
        .i_select_used(i_select_used), .i_shared_line(i_shared_line),
        .i_slot_used(i_slot_used), .i_command_byte_slots(i_command_byte_slots),
        .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data),
        .i_rd_addr(i_rd_addr), .i_sdi(i_sdi), .o_sclk(o_sclk), .o_sdo(o_sdo),
        .o_sdo_oe_n(o_sdo_oe_n), .o_cs_n(o_cs_n), .o_busy(o_busy), .o_done(o_done),
        .o_rd_data(o_rd_data), .o_frame_order_setting(o_frame_order_setting));
    ssp_peer peer (.i_clock(i_clock), .i_clear(clr), .i_sel_used(i_select_used),
        .i_sclk(o_sclk), .i_cs_n(o_cs_n), .i_oe_n(o_sdo_oe_n), .i_sdo(o_sdo),
        .i_pat(pat), .o_sdi(peer_sdi), .o_cap(cap), .o_ncap(ncap));
    // ****************
    // helpers and runs
    // ****************
    always @(posedge i_clock) begin
        sclk_p <= o_sclk;
        cyc <= cyc + 1;
        if (o_sclk && !sclk_p) begin
            rises <= rises + 1;
            per <= cyc - last;
            last <= cyc;
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr_en <= 1'b1;
        i_wr_addr <= a;
        i_wr_data <= d;
        @(posedge i_clock);
        i_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
        @(posedge i_clock);
        i_rd_addr <= a;
        repeat (2) @(posedge i_clock);
        #1 d = o_rd_data;
    endtask
    task automatic run(input logic [1:0] op, input logic [1:0] md, input logic [5:0] b,
                       input int n, output int p);
        int k, r0;
        @(posedge i_clock);
        i_op <= op;
        i_mode <= md;
        i_bits_per_word <= b;
        i_count <= (AW+1)'(n);
        i_start <= 1'b1;
        clr <= 1'b1;
        @(posedge i_clock);
        i_start <= 1'b0;
        clr <= 1'b0;
        r0 = rises;
        sawcs = 1'b0;
        #1;
        for (k = 0; k < 20000 && o_done !== 1'b1; k++) begin
            if (o_cs_n === 1'b0) sawcs = 1'b1;
            @(posedge i_clock);
            #1;
        end
        if (k == 20000) begin
            chk(1'b1, 1'b0, "no done");
            conclude();
        end
        p = rises - r0;
        @(posedge i_clock);
        #1 chk({o_cs_n, o_sclk, o_busy}, 3'h4, "idle after");
    endtask
    task automatic t_recv(input logic [1:0] md, input int b, input int n);
        int p, w, j, off;
        logic [31:0] e, d;
        off = md[1];
        pat = 64'hC3A596F01E2D7B48;
        run(SSP_OP_RECV, md, 6'(b), n, p);
        chk(p, n * b + off, "recv pulses");
        chk(per, 2 * RX_HALF, "recv period");
        for (w = 0; w < n; w++) begin
            e = 32'h0;
            for (j = 0; j < b; j++) e[md[0] ? j : b-1-j] = pat[off + w * b + j];
            rd(AW'(w), d);
            chk(d, e, "recv word");
        end
        $display("recv mode %0d bits %0d finished", md, b);
    endtask
    task automatic t_send(input logic [1:0] md, input int b, input int n);
        int p, w, j;
        logic [63:0] e;
        e = 64'h0;
        for (w = 0; w < n; w++) begin
            wr(AW'(w), src[w]);
            for (j = 0; j < b; j++) e = {e[62:0], src[w][md[0] ? b-1-j : j]};
        end
        run(SSP_OP_SEND, md, 6'(b), n, p);
        chk(p, n * b, "send pulses");
        chk(per, 2 * TX_HALF, "send period");
        chk(cap, e, "send bits");
        $display("send mode %0d bits %0d finished", md, b);
    endtask
    task automatic t_read(input logic [1:0] ord, input logic [2:0] sl, input logic sh,
                          input logic sel, input int n);
        int p, w, j, nc, off;
        logic [31:0] d;
        logic [7:0] e;
        logic [63:0] ec;
        ec = 64'h0;
        nc = 0;
        off = ord[1];
        @(posedge i_clock);
        i_frame_order_setting <= ord;
        i_order_we <= 1'b1;
        i_slot_used <= sl;
        i_shared_line <= sh;
        i_select_used <= sel;
        @(posedge i_clock);
        i_order_we <= 1'b0;
        #1 chk(o_frame_order_setting, ord, "order");
        for (w = 0; w < 3; w++) if (sl[w]) begin
            nc++;
            for (j = 0; j < 8; j++) begin
                ec = {ec[62:0], i_command_byte_slots[8*w + (ord[0] ? j : 7-j)]};
            end
        end
        run(SSP_OP_READ, 2'h0, BYTE_BITS, n, p);
        chk(p, nc * 8 + n * 8 + off, "read pulses");
        chk(per, 2 * RX_HALF, "read period");
        chk(ncap, nc * 8, "cmd count");
        chk(cap, ec, "cmd bits");
        chk(sawcs, sel, "select");
        for (w = 0; w < n; w++) begin
            for (j = 0; j < 8; j++) e[ord[0] ? j : 7-j] = pat[off + w * 8 + j];
            rd(AW'(w), d);
            chk(d, {24'h0, e}, "read byte");
        end
        $display("read order %0d finished", ord);
    endtask
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    initial begin
        {i_rst_n, i_start, i_order_we, i_select_used, i_shared_line, i_wr_en, clr} = 7'h0;
        {i_op, i_mode, i_frame_order_setting, i_slot_used} = 9'h0;
        {i_bits_per_word, i_count, i_wr_addr, i_rd_addr, i_wr_data} = 51'h0;
        i_command_byte_slots = 24'h5AC3E1;
        {bad_count, comparisons, rises, per, cyc, last} = {6{32'h0}};
        pat = 64'h0;
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        #1 chk({o_sclk, o_cs_n, o_sdo_oe_n, o_busy, o_done, o_frame_order_setting},
               {5'h0C, ORDER_RESET}, "reset");
        t_recv(2'h0, 8, 2);
        t_recv(2'h1, 32, 2);
        t_recv(2'h2, 2, 1);
        t_recv(2'h3, 8, 1);
        t_send(2'h0, 2, 3);
        t_send(2'h1, 32, 2);
        t_read(2'h1, 3'h5, 1'b1, 1'b1, 2);
        t_read(2'h0, 3'h7, 1'b0, 1'b1, 1);
        t_read(2'h2, 3'h0, 1'b0, 1'b0, 1);
        t_read(2'h3, 3'h2, 1'b1, 1'b0, 1);
        conclude();
    end
endmodule
